/* File: design/tpas_top.sv */
`timescale 1ns/1ns
module tpas_top import tpas_pkg::*; #(
  parameter int REFHOLD_CYC = TPAS_REFHOLD_CYC,
  parameter int SETTLE_BASE = TPAS_SETTLE_BASE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] tuning_voltage_pin,
  input wire logic shutdown_n,
  output logic [7:0] tracking_filter_band_onehot,
  output logic tracking_filter_enable,
  output logic overload_detect_enable,
  output logic [1:0] power_monitor_mode,
  output logic onchip_agc_enable,
  output logic [2:0] attack_point_select,
  output logic low_side_injection,
  output logic [2:0] filter_trim_applied,
  output logic filter_trim_override,
  output logic [1:0] oscillator_active,
  output logic [3:0] subband_active,
  output logic [1:0] charge_pump_current,
  output logic converter_run,
  output logic reference_out_pin,
  output logic reference_out_enable
);
  initial begin
    if (REFHOLD_CYC < 1 || SETTLE_BASE < 1) $error("tpas_top: counts must be positive");
    if (SETTLE_BASE > 128) $error("tpas_top: settle count exceeds the wait counter");
  end

  typedef enum {S_IDLE, S_SETTLE, S_JUDGE, S_DONE} tpas_state_t;

  logic [7:0] mode_q, det_q, iff_q, osc_q, vas_q, rlsb_q, nlsb_q, rmsb_q, nmsb_q;
  logic [2:0] adc_s1_q, adc_s2_q, adc_latch_q;
  logic sd_s1_q, sd_s2_q;
  logic done_q, found_q, mode_conflict_q;
  tpas_vco_t cur_q, start_q;
  tpas_state_t st_q;
  logic [9:0] wait_q;
  logic [5:0] tries_q;
  logic [31:0] hold_q;
  logic ref_div_q;
  logic wr, rd, nlsb_wr, adc_locked, unmapped;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign nlsb_wr = wr && paddr == TPAS_A_NLSB;
  assign pready = 1'b1;
  assign unmapped = !(paddr inside {TPAS_A_MODE, TPAS_A_DET, TPAS_A_IFF, TPAS_A_OSC,
      TPAS_A_VAS, TPAS_A_RLSB, TPAS_A_NLSB, TPAS_A_VSTAT, TPAS_A_STAT, TPAS_A_ADC,
      TPAS_A_RMSB, TPAS_A_NMSB});
  assign pslverr = psel && penable && unmapped;

  // Pin inputs pass two flip-flops before use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_s1_q <= 3'd0;
      adc_s2_q <= 3'd0;
      sd_s1_q <= 1'b0;
      sd_s2_q <= 1'b0;
    end else begin
      adc_s1_q <= tuning_voltage_pin;
      adc_s2_q <= adc_s1_q;
      sd_s1_q <= shutdown_n;
      sd_s2_q <= sd_s1_q;
    end
  end

  // Register writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= TPAS_RESET_ZERO;
      det_q <= TPAS_RESET_ZERO;
      iff_q <= TPAS_RESET_ZERO;
      osc_q <= TPAS_RESET_ZERO;
      vas_q <= TPAS_RESET_ZERO;
      rlsb_q <= TPAS_RESET_ZERO;
      nlsb_q <= TPAS_RESET_ZERO;
      rmsb_q <= TPAS_RESET_ZERO;
      nmsb_q <= TPAS_RESET_ZERO;
    end else if (wr) begin
      case (paddr)
        TPAS_A_MODE: mode_q <= pwdata[7:0];
        TPAS_A_DET: det_q <= pwdata[7:0];
        TPAS_A_IFF: iff_q <= pwdata[7:0];
        TPAS_A_OSC: osc_q <= pwdata[7:0];
        TPAS_A_VAS: vas_q <= {1'b0, pwdata[6:0]};
        TPAS_A_RLSB: rlsb_q <= pwdata[7:0];
        TPAS_A_NLSB: nlsb_q <= pwdata[7:0];
        TPAS_A_RMSB: rmsb_q <= pwdata[7:0];
        TPAS_A_NMSB: nmsb_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Field decode: MODE[2:0] band, [3] bypass, [4] injection.
  always_comb begin
    tracking_filter_band_onehot = 8'h01 << mode_q[2:0];
  end
  assign tracking_filter_enable = !mode_q[3];
  assign low_side_injection = mode_q[4];
  assign overload_detect_enable = !rlsb_q[2];
  assign attack_point_select = det_q[2:0];
  assign power_monitor_mode = det_q[4:3];
  assign onchip_agc_enable = det_q[4:3] == TPAS_DET_AGC;
  assign filter_trim_override = iff_q[3];
  assign filter_trim_applied = iff_q[3] ? iff_q[2:0] : 3'd0;

  // Mode 01 is unassigned and mode 00 is off (AGC is only mode 11); flag both.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_conflict_q <= 1'b0;
    end else begin
      mode_conflict_q <= det_q[4:3] == TPAS_DET_OFF || det_q[4:3] == 2'b01;
    end
  end

  // Lock decode of the converter code.
  always_comb begin
    case (adc_s2_q)
      3'b001, 3'b010, 3'b101, 3'b110: adc_locked = 1'b1;
      default: adc_locked = 1'b0;
    endcase
  end

  // Converter latch capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_latch_q <= 3'd0;
    end else if (vas_q[4] && ((wr && paddr == TPAS_A_VAS && pwdata[5]) ||
        (vas_q[0] && st_q == S_JUDGE))) begin
      adc_latch_q <= adc_s2_q;
    end
  end
  assign converter_run = vas_q[4];

  // Autoselect search. AUTOSELECT_ENABLE: [0] enable, [1] start point, [3:2] settle, [4] conv, [5] latch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      cur_q <= '0;
      start_q <= '0;
      wait_q <= 10'd0;
      tries_q <= 6'd0;
      done_q <= 1'b0;
      found_q <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE, S_DONE: begin
          if (!vas_q[0]) begin
            cur_q <= tpas_vco_t'(osc_q[5:0]);
          end
          if (nlsb_wr && vas_q[0]) begin
            if (!vas_q[1]) begin
              cur_q <= tpas_vco_t'(osc_q[5:0]);
            end
            done_q <= 1'b0;
            found_q <= 1'b0;
            tries_q <= 6'd0;
            wait_q <= 10'((SETTLE_BASE << vas_q[3:2]) - 1);
            st_q <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          if (wait_q == 10'd0) begin
            st_q <= S_JUDGE;
          end else begin
            wait_q <= wait_q - 10'd1;
          end
        end
        S_JUDGE: begin
          if (adc_locked) begin
            done_q <= 1'b1;
            found_q <= 1'b1;
            st_q <= S_DONE;
          end else if (tries_q == 6'd47) begin
            done_q <= 1'b1;
            found_q <= 1'b0;
            st_q <= S_DONE;
          end else begin
            tries_q <= tries_q + 6'd1;
            if (cur_q.sub == 4'hf) begin
              cur_q.sub <= 4'h0;
              cur_q.osc <= (cur_q.osc >= TPAS_NUM_OSC - 2'd1) ? 2'd0 : cur_q.osc + 2'd1;
            end else begin
              cur_q.sub <= cur_q.sub + 4'h1;
            end
            wait_q <= 10'((SETTLE_BASE << vas_q[3:2]) - 1);
            st_q <= S_SETTLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  assign oscillator_active = cur_q.osc;
  assign subband_active = cur_q.sub;

  // Pump current: RLSB[6] auto select, [1:0] manual code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_pump_current <= TPAS_CP_2MA0;
    end else if (rlsb_q[6]) begin
      charge_pump_current <= {cur_q.sub[3], adc_latch_q[2]};
    end else begin
      charge_pump_current <= rlsb_q[1:0];
    end
  end

  // Reference divider and startup hold.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 32'd0;
      ref_div_q <= 1'b0;
      reference_out_enable <= 1'b0;
      reference_out_pin <= 1'b0;
    end else begin
      ref_div_q <= !ref_div_q;
      if (!sd_s2_q) begin
        hold_q <= 32'd0;
        reference_out_enable <= 1'b0;
      end else if (hold_q < 32'(REFHOLD_CYC - 1)) begin
        hold_q <= hold_q + 32'd1;
      end else begin
        reference_out_enable <= 1'b1;
      end
      reference_out_pin <= reference_out_enable && ref_div_q;
    end
  end

  // Read mux.
  always_comb begin
    prdata = 32'h0;
    if (rd) begin
      case (paddr)
        TPAS_A_MODE: prdata[7:0] = mode_q;
        TPAS_A_DET: prdata[7:0] = det_q;
        TPAS_A_IFF: prdata[7:0] = iff_q;
        TPAS_A_OSC: prdata[7:0] = osc_q;
        TPAS_A_VAS: prdata[7:0] = vas_q;
        TPAS_A_RLSB: prdata[7:0] = rlsb_q;
        TPAS_A_NLSB: prdata[7:0] = nlsb_q;
        TPAS_A_RMSB: prdata[7:0] = rmsb_q;
        TPAS_A_NMSB: prdata[7:0] = nmsb_q;
        TPAS_A_VSTAT: prdata[7:0] = {done_q, found_q, cur_q};
        TPAS_A_STAT: prdata[7:0] = {3'd0, mode_conflict_q, adc_locked, adc_latch_q};
        TPAS_A_ADC: prdata[7:0] = {5'd0, adc_s2_q};
        default: prdata = 32'h0;
      endcase
    end
  end
endmodule : tpas_top

/* File: design/tpas_pkg.sv */
package tpas_pkg;
  localparam logic [7:0] TPAS_A_MODE = 8'h00;
  localparam logic [7:0] TPAS_A_DET = 8'h04;
  localparam logic [7:0] TPAS_A_IFF = 8'h08;
  localparam logic [7:0] TPAS_A_OSC = 8'h0c;
  localparam logic [7:0] TPAS_A_VAS = 8'h10;
  localparam logic [7:0] TPAS_A_RLSB = 8'h14;
  localparam logic [7:0] TPAS_A_NLSB = 8'h18;
  localparam logic [7:0] TPAS_A_VSTAT = 8'h1c;
  localparam logic [7:0] TPAS_A_STAT = 8'h20;
  localparam logic [7:0] TPAS_A_ADC = 8'h24;
  localparam logic [7:0] TPAS_A_RMSB = 8'h28;
  localparam logic [7:0] TPAS_A_NMSB = 8'h2c;
  localparam logic [7:0] TPAS_RESET_ZERO = 8'h00;
  localparam logic [1:0] TPAS_NUM_OSC = 2'd3;
  localparam int TPAS_CLK_HZ = 10000000;
  localparam int TPAS_REFHOLD_US = 3000;
  localparam int TPAS_REFHOLD_CYC = TPAS_REFHOLD_US * (TPAS_CLK_HZ / 1000000);
  localparam int TPAS_SETTLE_BASE = 16;
  typedef enum logic [1:0] {
    TPAS_DET_OFF = 2'b00, TPAS_DET_RMS = 2'b10, TPAS_DET_AGC = 2'b11
  } tpas_detmode_t;
  typedef enum logic [1:0] {
    TPAS_CP_2MA0 = 2'b00, TPAS_CP_3MA0 = 2'b01, TPAS_CP_1MA5 = 2'b10, TPAS_CP_2MA5 = 2'b11
  } tpas_cpcode_t;
  typedef struct packed {
    logic [1:0] osc;
    logic [3:0] sub;
  } tpas_vco_t;
endpackage : tpas_pkg

/* File: verif/tpas_checker.sv */
`timescale 1ns/1ns
module tpas_checker import tpas_pkg::*; #(
  parameter int REFHOLD_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic shutdown_n,
  input wire logic [7:0] tracking_filter_band_onehot,
  input wire logic tracking_filter_enable,
  input wire logic overload_detect_enable,
  input wire logic [1:0] power_monitor_mode,
  input wire logic onchip_agc_enable,
  input wire logic low_side_injection,
  input wire logic [2:0] filter_trim_applied,
  input wire logic reference_out_pin,
  input wire logic reference_out_enable
);
  logic [31:0] up_q;
  wire w = psel && penable && pwrite;
  // Counts cycles since shutdown was last released, holding at REFHOLD_CYC.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= '0;
    else if (!shutdown_n) up_q <= '0;
    else if (up_q < REFHOLD_CYC) up_q <= up_q + 1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_band;
    w && paddr == TPAS_A_MODE |=> tracking_filter_band_onehot == 8'h01 << $past(pwdata[2:0]);
  endproperty
  a_band: assert property (p_band) else $error("band wrong");
  property p_byp;
    w && paddr == TPAS_A_MODE |=> tracking_filter_enable == !$past(pwdata[3]);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass wrong");
  property p_inj;
    w && paddr == TPAS_A_MODE |=> low_side_injection == $past(pwdata[4]);
  endproperty
  a_inj: assert property (p_inj) else $error("injection wrong");
  property p_ovl;
    w && paddr == TPAS_A_RLSB |=> overload_detect_enable == !$past(pwdata[2]);
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload wrong");
  property p_det;
    w && paddr == TPAS_A_DET && pwdata[4:3] != 2'b01 |=> power_monitor_mode ==
      $past(pwdata[4:3]) && onchip_agc_enable == &$past(pwdata[4:3]);
  endproperty
  a_det: assert property (p_det) else $error("mode wrong");
  property p_trim;
    w && paddr == TPAS_A_IFF |=> filter_trim_applied ==
      ($past(pwdata[3]) ? $past(pwdata[2:0]) : 3'h0);
  endproperty
  a_trim: assert property (p_trim) else $error("trim wrong");
  property p_div;
    reference_out_enable && $past(reference_out_enable) && $past(reference_out_enable, 2)
      |-> $changed(reference_out_pin);
  endproperty
  a_div: assert property (p_div) else $error("divide wrong");
  property p_hold;
    $rose(reference_out_enable) |-> up_q >= REFHOLD_CYC;
  endproperty
  a_hold: assert property (p_hold) else $error("hold too short");
endmodule : tpas_checker
bind tpas_top tpas_checker #(.REFHOLD_CYC(REFHOLD_CYC)) i_tpas_checker (.*);

/* File: verif/tpas_loop_model.sv */
`timescale 1ns/1ns
module tpas_loop_model (
  input wire logic [1:0] oscillator_active,
  input wire logic [3:0] subband_active,
  input wire logic [5:0] tgt,
  input wire logic [2:0] lock,
  input wire logic [2:0] miss,
  output logic [2:0] tuning_voltage_pin
);
  // The loop settles only on the target oscillator and sub-band.
  assign tuning_voltage_pin = {oscillator_active, subband_active} == tgt ? lock : miss;
endmodule : tpas_loop_model

/* File: verif/tpas_top_tb.sv */
`timescale 1ns/1ns
module tpas_top_tb;
  import tpas_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, shutdown_n, e;
  logic tracking_filter_enable, overload_detect_enable, onchip_agc_enable;
  logic low_side_injection, filter_trim_override, converter_run;
  logic reference_out_pin, reference_out_enable;
  logic [7:0] paddr, tracking_filter_band_onehot, s;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] tuning_voltage_pin, attack_point_select, filter_trim_applied, lock, miss;
  logic [1:0] power_monitor_mode, oscillator_active, charge_pump_current;
  logic [3:0] subband_active;
  logic [5:0] tgt;
  logic [5:0] tg [4] = '{6'h15, 6'h17, 6'h1c, 6'h28};
  logic [2:0] lk [4] = '{3'b101, 3'b010, 3'b110, 3'b010};
  int fails, n_compared;
  tpas_top #(.REFHOLD_CYC(20), .SETTLE_BASE(4)) i_tpas_top (.*);
  tpas_loop_model i_tpas_loop_model (.*);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    fails++;
    finish_test();
  end
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic poll(input int lim);
    repeat (lim) begin
      apb(1'b0, TPAS_A_VSTAT, 0);
      if (r[7] === 1'b1) break;
    end
  endtask : poll
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {shutdown_n, tgt, lock, miss, s} = {1'b1, 6'h3f, 3'b010, 3'b111, 8'h52};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk("band", tracking_filter_band_onehot, 8'h01);
    for (int i = 0; i < 8; i++) begin
      s = nxt(s);
      apb(1'b1, TPAS_A_MODE, {27'h0, s[4:3], i[2:0]});
      chk("band", tracking_filter_band_onehot, 8'h01 << i);
      chk("bypass", tracking_filter_enable, !s[3]);
      chk("side", low_side_injection, s[4]);
      apb(1'b1, TPAS_A_DET, {27'h0, i[1:0], s[2:0]});
      chk("attack", attack_point_select, s[2:0]);
      chk("agc", onchip_agc_enable, i[1:0] == 2'd3);
      apb(1'b0, TPAS_A_STAT, 0);
      chk("conflict", r[4], i[1:0] < 2);
      if (i[1:0] != 2'd1) chk("mode", power_monitor_mode, i[1:0]);
      apb(1'b1, TPAS_A_IFF, {28'h0, s[3:0]});
      chk("trim", filter_trim_applied, s[3] ? s[2:0] : 3'h0);
      chk("override", filter_trim_override, s[3]);
      apb(1'b1, TPAS_A_RLSB, {29'h0, s[5:3]});
      @(posedge pclk);
      chk("cp", charge_pump_current, s[4:3]);
      chk("ovl", overload_detect_enable, !s[5]);
    end
    apb(1'b0, 8'h40, 0);
    chk("slverr", e, 1'b1);
    $display("fields done");
    apb(1'b1, TPAS_A_OSC, 32'h13);
    apb(1'b1, TPAS_A_RMSB, 0);
    apb(1'b1, TPAS_A_RLSB, 32'h40);
    for (int k = 0; k < 4; k++) begin
      tgt = tg[k];
      lock = lk[k];
      apb(1'b1, TPAS_A_VAS, k ? 32'h33 : 32'h31);
      apb(1'b1, TPAS_A_NLSB, 0);
      poll(k == 1 ? 12 : 60);
      chk("found", r[7:0], {2'b11, tg[k]});
      chk("auto cp", charge_pump_current, {tg[k][3], lk[k][2]});
      chk("osc", {oscillator_active, subband_active}, tg[k]);
      if (k == 0) apb(1'b1, TPAS_A_OSC, 0);
    end
    {tgt, miss} = {6'h3f, 3'b011};
    apb(1'b1, TPAS_A_VAS, 32'h0d);
    apb(1'b1, TPAS_A_NLSB, 0);
    apb(1'b0, TPAS_A_VSTAT, 0);
    chk("busy", r[7], 1'b0);
    poll(700);
    repeat (8) @(posedge pclk);
    apb(1'b0, TPAS_A_VSTAT, 0);
    chk("fail", r[7:6], 2'b10);
    $display("search done");
    miss = 3'b110;
    apb(1'b1, TPAS_A_VAS, 32'h10);
    chk("conv", converter_run, 1'b1);
    apb(1'b1, TPAS_A_VAS, 32'h30);
    apb(1'b0, TPAS_A_STAT, 0);
    chk("latch", r[3:0], 4'b1110);
    miss = 3'b000;
    apb(1'b1, TPAS_A_VAS, 32'h10);
    apb(1'b0, TPAS_A_STAT, 0);
    chk("live", r[3:0], 4'b0110);
    $display("latch done");
    shutdown_n <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("refoff", reference_out_enable, 1'b0);
    shutdown_n <= 1'b1;
    repeat (40) @(posedge pclk);
    chk("refon", reference_out_enable, 1'b1);
    $display("refout done");
    finish_test();
  end
endmodule : tpas_top_tb
